// ==== rpps_regs.vh ====
`ifndef RPPS_REGS_VH
`define RPPS_REGS_VH

// register byte addresses (12-bit bus address)
`define RPPS_ADDR_W        12
`define RPPS_CFG_ADDR      12'h000
`define RPPS_FUSE_ADDR     12'h004
`define RPPS_IN_PAGE       4'h1
`define RPPS_OUT_PAGE      4'h2

// field positions
`define RPPS_LOCK_BIT      13
`define RPPS_FUSE_BIT      29
`define RPPS_SEL_W         4

// reset values
`define RPPS_SEL_RST       4'h0
`define RPPS_LOCK_RST      1'b0
`define RPPS_FUSE_RST      1'b1
`define RPPS_RD_RST        32'h0000_0000

// sizes
`define RPPS_NUM_IN        24
`define RPPS_NUM_SLOT      32
`define RPPS_NUM_FUNC      16

// idle level per peripheral input: receive lines and active-low selects idle high
`define RPPS_IN_IDLE       24'h41_8308

// peripheral input index ranges per pin group
`define RPPS_G1_FIRST      5
`define RPPS_G2_FIRST      11
`define RPPS_G3_FIRST      19

// pin slots without an output selector
`define RPPS_SLOT_NO_OUT_A 5'h02
`define RPPS_SLOT_NO_OUT_B 5'h12

// peripheral output indices
`define RPPS_F_UART1_TX    4'h0
`define RPPS_F_UART2_RTS   4'h1
`define RPPS_F_SPI1_SS     4'h2
`define RPPS_F_BUS_PWR     4'h3
`define RPPS_F_CMP1        4'h4
`define RPPS_F_ACMP2       4'h5
`define RPPS_F_SPI1_DO     4'h6
`define RPPS_F_SPI2_DO     4'h7
`define RPPS_F_CMP2        4'h8
`define RPPS_F_ACMP3       4'h9
`define RPPS_F_CMP4        4'hA
`define RPPS_F_CMP5        4'hB
`define RPPS_F_REFCLK      4'hC
`define RPPS_F_SPI2_SS     4'hD
`define RPPS_F_CMP3        4'hE
`define RPPS_F_ACMP1       4'hF

`endif

// ==== rpps_crossbar.v ====
`timescale 1ns/1ps
`include "rpps_regs.vh"

module rpps_crossbar #(
    parameter PKG_44_PIN   = 1,
    parameter USB_VARIANT  = 0,
    parameter VBAT_VARIANT = 0
) (
    input  wire        CLOCK,
    input  wire        NRST,
    input  wire [11:0] ADDR,
    input  wire [31:0] WR_DATA,
    input  wire        WR_EN,
    input  wire        RD_EN,
    output reg  [31:0] RD_DATA,
    input  wire        UNLOCK_OK,
    input  wire        FUSE_ONE_SESSION,
    input  wire [31:0] PIN_IN,
    input  wire [31:0] PIN_ANALOG,
    output reg  [31:0] PIN_OUT,
    output reg  [31:0] PIN_REMAP_OWN,
    input  wire [15:0] PERIPH_OUT,
    output reg  [23:0] PERIPH_IN,
    output reg         MAP_WRITE_LOCK
);

    // pin slot = {group, code}; B6 sits in the unused group 2 code 1 slot
    function pin_present;
        input [4:0] slot;
        begin
            pin_present = 1'b1;
            case (slot)
                5'h05: pin_present = (PKG_44_PIN != 0);
                5'h06: pin_present = (PKG_44_PIN != 0);
                5'h07: pin_present = (PKG_44_PIN != 0);
                5'h0D: pin_present = (PKG_44_PIN != 0);
                5'h0E: pin_present = (PKG_44_PIN != 0);
                5'h0F: pin_present = (PKG_44_PIN != 0);
                5'h15: pin_present = (PKG_44_PIN != 0);
                5'h16: pin_present = (PKG_44_PIN != 0);
                5'h17: pin_present = (PKG_44_PIN != 0);
                5'h1D: pin_present = (PKG_44_PIN != 0);
                5'h1E: pin_present = (PKG_44_PIN != 0);
                5'h1F: pin_present = (PKG_44_PIN != 0);
                5'h0B: pin_present = (USB_VARIANT == 0);
                5'h11: pin_present = (USB_VARIANT == 0);
                5'h1B: pin_present = (USB_VARIANT == 0);
                5'h13:
                    pin_present = (VBAT_VARIANT == 0);
                5'h12:
                    pin_present = 1'b0;
                default:
                    pin_present = 1'b1;
            endcase
        end
    endfunction

    function [1:0] in_group;
        input integer idx;
        begin
            if (idx >= `RPPS_G3_FIRST)
                in_group = 2'd3;
            else if (idx >= `RPPS_G2_FIRST)
                in_group = 2'd2;
            else if (idx >= `RPPS_G1_FIRST)
                in_group = 2'd1;
            else
                in_group = 2'd0;
        end
    endfunction

    function in_code_ok;
        input [1:0] grp;
        input [3:0] code;
        begin
            // group 2 codes 1 and 2 are never input sources; code 2 has no pin, and code 1 has none on a USB part
            if (grp == 2'd2 && (code == 4'h1 || code == 4'h2))
                in_code_ok = 1'b0;
            else
                in_code_ok = ~code[3];
        end
    endfunction

    // returns {valid, function index}
    function [4:0] out_map;
        input [1:0] grp;
        input [3:0] code;
        begin
            out_map = 5'h00;
            case (grp)
                2'd0: begin
                    case (code)
                        4'h0: out_map = 5'h00;
                        4'h1: out_map = {1'b1, `RPPS_F_UART1_TX};
                        4'h2: out_map = {1'b1, `RPPS_F_UART2_RTS};
                        4'h3: out_map = {1'b1, `RPPS_F_SPI1_SS};
                        4'h4: out_map = {(USB_VARIANT != 0), `RPPS_F_BUS_PWR};
                        4'h5: out_map = {1'b1, `RPPS_F_CMP1};
                        4'h6: out_map = 5'h00;
                        4'h7: out_map = {1'b1, `RPPS_F_ACMP2};
                        default: out_map = 5'h00;
                    endcase
                end
                2'd1: begin
                    case (code)
                        4'h0: out_map = 5'h00;
                        4'h1: out_map = 5'h00;
                        4'h2: out_map = 5'h00;
                        4'h3: out_map = {1'b1, `RPPS_F_SPI1_DO};
                        4'h4: out_map = {1'b1, `RPPS_F_SPI2_DO};
                        4'h5: out_map = {1'b1, `RPPS_F_CMP2};
                        4'h6: out_map = 5'h00;
                        4'h7: out_map = {1'b1, `RPPS_F_ACMP3};
                        default: out_map = 5'h00;
                    endcase
                end
                2'd2: begin
                    case (code)
                        4'h0: out_map = 5'h00;
                        4'h1: out_map = 5'h00;
                        4'h2: out_map = 5'h00;
                        4'h3: out_map = {1'b1, `RPPS_F_SPI1_DO};
                        4'h4: out_map = {1'b1, `RPPS_F_SPI2_DO};
                        4'h5: out_map = {1'b1, `RPPS_F_CMP4};
                        4'h6: out_map = {1'b1, `RPPS_F_CMP5};
                        4'h7: out_map = {1'b1, `RPPS_F_REFCLK};
                        default: out_map = 5'h00;
                    endcase
                end
                default: begin
                    case (code)
                        4'h0: out_map = 5'h00;
                        4'h1: out_map = 5'h00;
                        4'h2: out_map = 5'h00;
                        4'h3: out_map = 5'h00;
                        4'h4: out_map = {1'b1, `RPPS_F_SPI2_SS};
                        4'h5: out_map = {1'b1, `RPPS_F_CMP3};
                        4'h6: out_map = 5'h00;
                        4'h7: out_map = {1'b1, `RPPS_F_ACMP1};
                        default: out_map = 5'h00;
                    endcase
                end
            endcase
        end
    endfunction

    function has_out_reg;
        input [4:0] slot;
        begin
            has_out_reg = (slot != `RPPS_SLOT_NO_OUT_A) && (slot != `RPPS_SLOT_NO_OUT_B);
        end
    endfunction

    function is_in_addr;
        input [11:0] a;
        begin
            is_in_addr = (a[11:8] == `RPPS_IN_PAGE) && (a[1:0] == 2'b00) &&
                         (a[7:2] < `RPPS_NUM_IN);
        end
    endfunction

    function is_out_addr;
        input [11:0] a;
        begin
            is_out_addr = (a[11:8] == `RPPS_OUT_PAGE) && (a[1:0] == 2'b00) &&
                          (a[7] == 1'b0) && has_out_reg(a[6:2]);
        end
    endfunction

    // separate input and output selector sets
    reg  [3:0]  in_sel_q  [0:`RPPS_NUM_IN-1];
    reg  [3:0]  out_sel_q [0:`RPPS_NUM_SLOT-1];
    reg  [23:0] in_set_q;
    reg         lock_q;
    reg         lock_once_q;
    reg         fuse_q;
    reg         fuse_taken_q;
    reg  [31:0] rd_d;
    wire [23:0] periph_in_d;
    wire [31:0] pin_out_d;
    wire [31:0] pin_own_d;
    wire [4:0]  wr_in_idx;
    wire [4:0]  wr_slot;
    wire        cfg_wr;
    wire        sel_wr_ok;
    wire        lock_set_req;
    wire        lock_clr_req;
    wire        lock_frozen;
    wire [23:0] in_idle;
    integer     k;

    assign wr_in_idx = ADDR[6:2];
    assign wr_slot   = ADDR[6:2];
    assign cfg_wr    = WR_EN && (ADDR == `RPPS_CFG_ADDR);
    // locked writes are accepted and dropped
    assign sel_wr_ok = WR_EN && !lock_q;
    assign in_idle   = `RPPS_IN_IDLE;
    assign lock_set_req = cfg_wr && UNLOCK_OK && WR_DATA[`RPPS_LOCK_BIT];
    assign lock_clr_req = cfg_wr && UNLOCK_OK && !WR_DATA[`RPPS_LOCK_BIT];
    assign lock_frozen  = fuse_q && lock_once_q;

    // fuse is a static strap; sampled once after reset release
    always @(posedge CLOCK) begin
        if (!NRST) begin
            fuse_q       <= `RPPS_FUSE_RST;
            fuse_taken_q <= 1'b0;
        end else if (!fuse_taken_q) begin
            fuse_q       <= FUSE_ONE_SESSION;
            fuse_taken_q <= 1'b1;
        end
    end

    // lock bit; key sequence handled outside and reported on UNLOCK_OK
    always @(posedge CLOCK) begin
        if (!NRST) begin
            // reset is the only way out of a frozen lock
            lock_q      <= `RPPS_LOCK_RST;
            lock_once_q <= 1'b0;
        end else if (lock_set_req) begin
            lock_q      <= 1'b1;
            lock_once_q <= 1'b1;
        end else if (lock_clr_req && !lock_frozen) begin
            lock_q <= 1'b0;
        end
    end

    // input selector registers
    always @(posedge CLOCK) begin
        if (!NRST) begin
            in_set_q <= 24'h00_0000;
            for (k = 0; k < `RPPS_NUM_IN; k = k + 1) begin
                in_sel_q[k] <= `RPPS_SEL_RST;
            end
        end else if (sel_wr_ok && is_in_addr(ADDR)) begin
            in_sel_q[wr_in_idx] <= WR_DATA[3:0];
            in_set_q[wr_in_idx] <= 1'b1;
        end
    end

    // output selector registers
    always @(posedge CLOCK) begin
        if (!NRST) begin
            for (k = 0; k < `RPPS_NUM_SLOT; k = k + 1) begin
                out_sel_q[k] <= `RPPS_SEL_RST;
            end
        end else if (sel_wr_ok && is_out_addr(ADDR)) begin
            out_sel_q[wr_slot] <= WR_DATA[3:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < `RPPS_NUM_IN; gi = gi + 1) begin : g_in
            wire [1:0] grp  = in_group(gi);
            wire [3:0] code = in_sel_q[gi];
            wire [4:0] slot = {grp, code[2:0]};
            wire       ok;
            assign ok = in_set_q[gi] && in_code_ok(grp, code) &&
                        pin_present(slot) && !PIN_ANALOG[slot];
            assign periph_in_d[gi] = ok ? PIN_IN[slot] : in_idle[gi];
        end
        for (gi = 0; gi < `RPPS_NUM_SLOT; gi = gi + 1) begin : g_out
            wire [31:0] gi_w = gi;
            wire [4:0] slot = gi_w[4:0];
            wire [4:0] fsel = out_map(slot[4:3], out_sel_q[gi]);
            wire       own;
            assign own = fsel[4] && has_out_reg(slot) && pin_present(slot) &&
                         !PIN_ANALOG[gi];
            // remap takes the pin over gpio
            assign pin_own_d[gi] = own;
            assign pin_out_d[gi] = own & PERIPH_OUT[fsel[3:0]];
        end
    endgenerate

    // read mux; unmapped addresses read zero
    always @* begin
        rd_d = `RPPS_RD_RST;
        if (ADDR == `RPPS_CFG_ADDR)
            rd_d[`RPPS_LOCK_BIT] = lock_q;
        else if (ADDR == `RPPS_FUSE_ADDR)
            rd_d[`RPPS_FUSE_BIT] = fuse_q;
        else if (is_in_addr(ADDR))
            rd_d[3:0] = in_sel_q[wr_in_idx];
        else if (is_out_addr(ADDR))
            rd_d[3:0] = out_sel_q[wr_slot];
    end

    // outputs registered: one cycle of routing latency traded for clean pad timing
    always @(posedge CLOCK) begin
        if (!NRST) begin
            RD_DATA <= `RPPS_RD_RST;
        end else begin
            RD_DATA <= RD_EN ? rd_d : `RPPS_RD_RST;
        end
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            PIN_OUT <= 32'h0000_0000;
        end else begin
            PIN_OUT <= pin_out_d;
        end
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            PIN_REMAP_OWN <= 32'h0000_0000;
        end else begin
            PIN_REMAP_OWN <= pin_own_d;
        end
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            PERIPH_IN <= `RPPS_IN_IDLE;
        end else begin
            PERIPH_IN <= periph_in_d;
        end
    end

    always @(posedge CLOCK) begin
        if (!NRST) begin
            MAP_WRITE_LOCK <= `RPPS_LOCK_RST;
        end else begin
            MAP_WRITE_LOCK <= lock_q;
        end
    end

endmodule // rpps_crossbar

// ==== rpps_chk.sv ====
`timescale 1ns/1ps
module rpps_chk (
    input wire        CLOCK,
    input wire        NRST,
    input wire [11:0] ADDR,
    input wire [31:0] WR_DATA,
    input wire        WR_EN,
    input wire        RD_EN,
    input wire [31:0] RD_DATA,
    input wire        UNLOCK_OK,
    input wire        FUSE_ONE_SESSION,
    input wire [31:0] PIN_ANALOG,
    input wire [31:0] PIN_REMAP_OWN,
    input wire [31:0] PIN_OUT,
    input wire [23:0] PERIPH_IN,
    input wire        MAP_WRITE_LOCK
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    rd_idle_a: assert property (!$past(RD_EN) |-> RD_DATA == 32'h0000_0000)
        else $error("read data outside read slot");
    analog_wins_a: assert property ((PIN_REMAP_OWN & $past(PIN_ANALOG)) == 32'h0000_0000)
        else $error("analog pin taken by remap");
    in_idle_a: assert property ($rose(NRST) |-> PERIPH_IN == 24'h41_8308)
        else $error("inputs not idle after reset");
    out_reset_a: assert property ($rose(NRST) |-> PIN_REMAP_OWN == 32'h0000_0000)
        else $error("pins owned after reset");
    lock_set_a: assert property (WR_EN && ADDR == 12'h000 && WR_DATA[13] && UNLOCK_OK
        |-> ##2 MAP_WRITE_LOCK)
        else $error("lock not set");
    lock_key_a: assert property ($changed(MAP_WRITE_LOCK) |-> $past(WR_EN, 2)
        && $past(UNLOCK_OK, 2) && $past(ADDR, 2) == 12'h000)
        else $error("lock changed without key");
    one_session_a: assert property (MAP_WRITE_LOCK && FUSE_ONE_SESSION |=> MAP_WRITE_LOCK)
        else $error("frozen lock cleared");
    fuse_read_a: assert property (RD_EN && ADDR == 12'h004
        |=> RD_DATA[29] == $past(FUSE_ONE_SESSION))
        else $error("fuse bit misread");
    no_sel_slot_a: assert property (!PIN_REMAP_OWN[2] && !PIN_REMAP_OWN[18])
        else $error("slot without selector owned");
endmodule // rpps_chk

bind rpps_crossbar rpps_chk chk (.CLOCK, .NRST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .UNLOCK_OK, .FUSE_ONE_SESSION, .PIN_ANALOG, .PIN_REMAP_OWN, .PIN_OUT, .PERIPH_IN,
    .MAP_WRITE_LOCK);

// ==== rpps_periph_model.sv ====
`timescale 1ns/1ps
module rpps_periph_model (
    input  wire        clock,
    output reg  [31:0] pad_q,
    output wire [15:0] func_level
);
    // levels move every cycle so a stuck or crossed route shows
    initial pad_q = 32'h1D2C_3B4A;
    always @(posedge clock) begin
        pad_q <= {pad_q[30:0], pad_q[31] ^ pad_q[21] ^ pad_q[1] ^ pad_q[0]};
    end
    assign func_level = pad_q[15:0] ^ pad_q[31:16];
endmodule // rpps_periph_model

// ==== rpps_crossbar_test.sv ====
`timescale 1ns/1ps
`include "rpps_regs.vh"
module rpps_crossbar_test;
    reg         CLOCK = 1'b0;
    reg         NRST = 1'b0;
    reg  [11:0] ADDR = 12'h000;
    reg  [31:0] WR_DATA = 32'h0000_0000;
    reg         WR_EN = 1'b0;
    reg         RD_EN = 1'b0;
    reg         UNLOCK_OK = 1'b0;
    reg         FUSE_ONE_SESSION = 1'b1;
    reg  [31:0] PIN_ANALOG = 32'h0000_0000;
    wire [31:0] RD_DATA, PIN_IN, PIN_OUT, PIN_REMAP_OWN;
    wire [15:0] PERIPH_OUT;
    wire [23:0] PERIPH_IN;
    wire        MAP_WRITE_LOCK;
    reg  [23:0] idle = `RPPS_IN_IDLE;
    int         bad_count = 0;
    int         samples_checked = 0;
    int         ins[4] = '{0, 9, 15, 22};
    int         outs[4] = '{0, 8, 19, 24};
    integer     g, c;

    rpps_crossbar uut (.CLOCK, .NRST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA, .UNLOCK_OK,
        .FUSE_ONE_SESSION, .PIN_IN, .PIN_ANALOG, .PIN_OUT, .PIN_REMAP_OWN, .PERIPH_OUT,
        .PERIPH_IN, .MAP_WRITE_LOCK);
    rpps_periph_model pads (.clock(CLOCK), .pad_q(PIN_IN), .func_level(PERIPH_OUT));

    always #12.5 CLOCK = ~CLOCK;

    task conclude;
        if (bad_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic cmp(input [31:0] got, input [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input [11:0] a, input [31:0] d);
        @(posedge CLOCK);
        ADDR <= a;
        WR_DATA <= d;
        WR_EN <= 1'b1;
        @(posedge CLOCK);
        WR_EN <= 1'b0;
    endtask
    task automatic rd(input [11:0] a, input [31:0] exp);
        @(posedge CLOCK);
        ADDR <= a;
        RD_EN <= 1'b1;
        @(posedge CLOCK);
        RD_EN <= 1'b0;
        @(negedge CLOCK);
        cmp(RD_DATA, exp);
    endtask
    task automatic do_reset(input f);
        @(posedge CLOCK);
        NRST <= 1'b0;
        FUSE_ONE_SESSION <= f;
        repeat (5) @(posedge CLOCK);
        NRST <= 1'b1;
        @(negedge CLOCK);
        cmp(PERIPH_IN, idle);
        cmp(PIN_REMAP_OWN, 0);
        // lock writes only once the fuse sample has landed
        @(posedge CLOCK);
    endtask
    task automatic chk_in(input int idx, input int slot, input bit pin);
        reg e;
        @(negedge CLOCK);
        e = pin ? PIN_IN[slot] : idle[idx];
        repeat (3) begin
            @(negedge CLOCK);
            cmp(PERIPH_IN[idx], e);
            e = pin ? PIN_IN[slot] : idle[idx];
        end
    endtask
    task automatic chk_out(input int slot, input int f);
        reg e;
        bit on;
        @(negedge CLOCK);
        e = PERIPH_OUT[f[3:0]];
        on = f != 16 && !PIN_ANALOG[slot];
        repeat (3) begin
            @(negedge CLOCK);
            cmp(PIN_REMAP_OWN[slot], on);
            if (on) cmp(PIN_OUT[slot], e);
            e = PERIPH_OUT[f[3:0]];
        end
    endtask
    // bus power code stays unmapped on a non-usb part
    function automatic int fmap(input int g, input int c);
        case (g * 16 + c)
            8'h01: fmap = 0;
            8'h02: fmap = 1;
            8'h03: fmap = 2;
            8'h05: fmap = 4;
            8'h07: fmap = 5;
            8'h13, 8'h23: fmap = 6;
            8'h14, 8'h24: fmap = 7;
            8'h15: fmap = 8;
            8'h17: fmap = 9;
            8'h25: fmap = 10;
            8'h26: fmap = 11;
            8'h27: fmap = 12;
            8'h34: fmap = 13;
            8'h35: fmap = 14;
            8'h37: fmap = 15;
            default: fmap = 16;
        endcase
    endfunction

    initial begin
        #(25 * 5000);
        bad_count++;
        conclude;
    end

    initial begin
        do_reset(1'b1);
        chk_in(3, 0, 1'b0);
        rd(12'h004, 32'h2000_0000);
        wr(12'h004, 32'h0000_0000);
        rd(12'h004, 32'h2000_0000);
        rd(12'h3F0, 32'h0000_0000);
        rd(12'h200, 32'h0000_0000);
        for (g = 0; g < 4; g++)
            for (c = 0; c < 9; c++) begin
                wr(12'h100 + 4 * ins[g], c);
                chk_in(ins[g], g * 8 + c, c < 8 && !(g == 2 && c inside {1, 2}));
            end
        for (g = 0; g < 4; g++)
            for (c = 0; c < 16; c++) begin
                wr(12'h200 + 4 * outs[g], 32'hFFFF_FFF0 | c);
                chk_out(outs[g], fmap(g, c));
                rd(12'h200 + 4 * outs[g], c);
            end
        wr(12'h260, 7);
        PIN_ANALOG <= 32'h0100_0000;
        chk_out(24, 15);
        PIN_ANALOG <= 32'h0000_0000;
        wr(12'h100, 3);
        wr(12'h000, 32'h0000_2000);
        rd(12'h000, 32'h0000_0000);
        UNLOCK_OK <= 1'b1;
        wr(12'h000, 32'h0000_2000);
        rd(12'h000, 32'h0000_2000);
        cmp(MAP_WRITE_LOCK, 1);
        wr(12'h100, 5);
        rd(12'h100, 3);
        wr(12'h000, 32'h0000_0000);
        rd(12'h000, 32'h0000_2000);
        do_reset(1'b0);
        rd(12'h000, 32'h0000_0000);
        wr(12'h000, 32'h0000_2000);
        wr(12'h000, 32'h0000_0000);
        rd(12'h000, 32'h0000_0000);
        wr(12'h100, 6);
        rd(12'h100, 6);
        conclude;
    end
endmodule // rpps_crossbar_test
